/* File: src/rss_pkg.sv */
// Package for the regulator start-up sequencer: timing and sizing constants.
// Assumes a 20 MHz core clock; the ramp step cycle count derives from that rate.
package rss_pkg;

  localparam int unsigned CLK_HZ        = 20000000;
  // Soft-start ramp, in microvolts per microsecond
  localparam int unsigned SS_RATE_UV_US = 200;
  // Final soft-start level, in microvolts
  localparam int unsigned SS_FINAL_UV   = 1500000;
  // Effective ramp span that sets output rise time, in microvolts
  localparam int unsigned SS_LOW_UV     = 150000;
  localparam int unsigned SS_HIGH_UV    = 750000;
  // One level step equals 1 mV; time per step in ns, then in clock cycles
  localparam int unsigned SS_STEP_UV    = 1000;
  localparam int unsigned SS_STEP_NS    = SS_STEP_UV * 1000 / SS_RATE_UV_US;
  localparam int unsigned SS_STEP_CYC   = SS_STEP_NS / (1000000000 / CLK_HZ);
  // Level in mV steps
  localparam int unsigned SS_MAX_CODE   = SS_FINAL_UV / SS_STEP_UV;
  localparam int unsigned SS_LOW_CODE   = SS_LOW_UV / SS_STEP_UV;
  localparam int unsigned SS_HIGH_CODE  = SS_HIGH_UV / SS_STEP_UV;
  localparam int unsigned SS_W          = 11;
  // Output rise time in ns
  localparam int unsigned T_RISE_NS     = (SS_HIGH_UV - SS_LOW_UV) * 1000 / SS_RATE_UV_US;

  // Pre-bias stepping: eighths of a period, pulses per step
  localparam int unsigned PB_STEPS      = 8;
  localparam int unsigned PB_PULSES     = 16;
  localparam int unsigned PERIOD_CYC    = 32;

  typedef enum logic [1:0] {
    RSS_IDLE  = 2'b00,
    RSS_WAIT  = 2'b01,
    RSS_STEP  = 2'b10,
    RSS_RUN   = 2'b11
  } rss_state_t;

endpackage

/* File: src/rss_sequencer.sv */
// Contract
// R1: Drivers off while either monitor is low
// R2: Resume switching once both monitors valid
// R3: Supply-valid only when both monitors valid
// R4: Soft-start begins when supply-valid asserts
// R5: Low side off until first high pulse
// R6: Low side duty from eighth, eighth steps
// R7: Sixteen pulses per step, eight steps
// R8: Soft-start level rises linearly to final
// R9: Rise time set by span and rate
// R10: Fault guards active during soft-start
// R11: Level stepped by internal timed enable
// R12: Supply-valid loss resets ramp and stepping
//
// Start-up sequencer: supply-valid, soft-start level, pre-bias low-side stepping.
// Assumes monitor and guard inputs are synchronous comparator results and
// hs_pwm is the modulator's high-side request, one pulse per switching period.
`timescale 1ns/1ps
module rss_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned STEP_CYC   = SS_STEP_CYC,
  parameter int unsigned PERIOD_LEN = PERIOD_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Monitor results
  input  wire logic              bias_ok,
  input  wire logic              enable_ok,
  // Modulator requests and fault guards
  input  wire logic              hs_pwm,
  input  wire logic              ls_pwm,
  input  wire logic              overcurrent_guard,
  input  wire logic              overvoltage_guard,
  // Driver permissions and status
  output logic                   high_side_switch,
  output logic                   low_side_switch,
  output logic                   supply_valid,
  output logic                   soft_start_active,
  output logic                   rise_window,
  output logic [SS_W-1:0]        soft_start_level,
  output logic [3:0]             ls_duty_eighths
);

  localparam int unsigned TW = $clog2(STEP_CYC + 1);
  localparam int unsigned PW = $clog2(PERIOD_LEN + 1);
  localparam logic [SS_W-1:0] SS_MAX = SS_W'(SS_MAX_CODE);
  localparam logic [SS_W-1:0] SS_LO  = SS_W'(SS_LOW_CODE);
  localparam logic [SS_W-1:0] SS_HI  = SS_W'(SS_HIGH_CODE);

  rss_state_t        state_q;
  logic              pwr_ok;
  logic              fault;
  logic [TW-1:0]     tick_cnt_q;
  logic              tick;
  logic [PW-1:0]     phase_q;
  logic              hs_prev_q;
  logic              hs_rise;
  logic [4:0]        pulse_cnt_q;
  logic [3:0]        duty_q;
  logic              ls_window;

  assign pwr_ok  = bias_ok & enable_ok;                      // R3
  assign fault   = overcurrent_guard | overvoltage_guard;    // R10
  assign tick    = (tick_cnt_q == TW'(STEP_CYC - 1));
  assign hs_rise = hs_pwm & ~hs_prev_q;
  // Low-side allowed for duty eighths of the period from the start of the high pulse
  assign ls_window = (phase_q < PW'((PERIOD_LEN / PB_STEPS) * duty_q));

  // Sequencer held off: a monitor is low or start-up has not begun
  function automatic logic seq_hold(input logic ok, input rss_state_t st);
    return !ok || st == RSS_IDLE;
  endfunction

  // All start-up pulses counted at the present duty
  function automatic logic pulses_done(input logic [4:0] cnt);
    return cnt == 5'(PB_PULSES);
  endfunction

  // Low-side duty has reached the full period
  function automatic logic duty_full(input logic [3:0] duty);
    return duty == 4'(PB_STEPS);
  endfunction

  // Power-on-ready flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_valid <= 1'b0;
    end else begin
      supply_valid <= pwr_ok;                                 // R3
    end
  end

  // Ramp timing enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= '0;
    end else if (seq_hold(pwr_ok, state_q) || tick) begin
      tick_cnt_q <= '0;                                       // R11
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end

  // Sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= RSS_IDLE;
    end else if (!pwr_ok) begin
      state_q <= RSS_IDLE;                                    // R12
    end else begin
      unique case (state_q)
        RSS_IDLE: begin
          if (supply_valid) begin
            state_q <= RSS_WAIT;                              // R4
          end
        end
        RSS_WAIT: begin
          if (hs_rise && !fault) begin
            state_q <= RSS_STEP;                              // R5
          end
        end
        RSS_STEP: begin
          if (duty_full(duty_q) && pulses_done(pulse_cnt_q)) begin
            state_q <= RSS_RUN;                               // R7
          end
        end
        RSS_RUN: begin
          state_q <= RSS_RUN;                                 // R2
        end
      endcase
    end
  end

  // Soft-start level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_start_level <= '0;
    end else if (seq_hold(pwr_ok, state_q)) begin
      soft_start_level <= '0;                                 // R12
    end else if (tick && soft_start_level < SS_MAX) begin
      soft_start_level <= soft_start_level + SS_W'(1);        // R8
    end
  end

  // Status flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_start_active <= 1'b0;
      rise_window       <= 1'b0;
    end else begin
      soft_start_active <= pwr_ok && state_q != RSS_IDLE && soft_start_level < SS_MAX;
      rise_window       <= pwr_ok && soft_start_level >= SS_LO
                           && soft_start_level < SS_HI;       // R9
    end
  end

  // Switching period phase, restarted on each high-side pulse
  // Saturates so a missing high pulse cannot reopen the low-side window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hs_prev_q <= 1'b0;
      phase_q   <= '0;
    end else begin
      hs_prev_q <= hs_pwm;
      if (hs_rise) begin
        phase_q <= '0;
      end else if (phase_q != PW'(PERIOD_LEN)) begin
        phase_q <= phase_q + PW'(1);
      end
    end
  end

  // Pre-bias duty stepping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duty_q      <= 4'h0;
      pulse_cnt_q <= 5'h00;
    end else if (seq_hold(pwr_ok, state_q) || state_q == RSS_WAIT) begin
      duty_q      <= 4'h1;                                    // R12
      pulse_cnt_q <= 5'h00;
    end else if (state_q == RSS_STEP && hs_rise) begin
      if (pulses_done(pulse_cnt_q)) begin
        if (!duty_full(duty_q)) begin
          duty_q <= duty_q + 4'h1;                            // R6
        end
        pulse_cnt_q <= 5'h01;
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 5'h01;                   // R7
      end
    end
  end

  // Reported low-side limit, zero until stepping starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_duty_eighths <= 4'h0;
    end else if (seq_hold(pwr_ok, state_q) || state_q == RSS_WAIT) begin
      ls_duty_eighths <= 4'h0;                                // R5
    end else begin
      ls_duty_eighths <= duty_q;                              // R6
    end
  end

  // Driver permissions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      high_side_switch <= 1'b0;
      low_side_switch  <= 1'b0;
    end else if (seq_hold(pwr_ok, state_q)) begin
      high_side_switch <= 1'b0;                               // R1
      low_side_switch  <= 1'b0;
    end else begin
      high_side_switch <= hs_pwm && !fault;                   // R10
      unique case (state_q)
        RSS_WAIT: low_side_switch <= 1'b0;                    // R5
        RSS_STEP: low_side_switch <= ls_pwm && !hs_pwm && ls_window && !overcurrent_guard; // R6
        RSS_IDLE, RSS_RUN: low_side_switch <= ls_pwm && !hs_pwm && !overcurrent_guard;
      endcase
    end
  end

endmodule

/* File: tb/rss_sequencer_asserts.sv */
// Checker for the start-up sequencer, watching its ports only.
// Assumes it is bound to rss_sequencer and shares its clock and reset.
`timescale 1ns/1ps
module rss_sequencer_chk
  import rss_pkg::*;
(
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // Monitors, high-side request and guards
  input wire logic            bias_ok,
  input wire logic            enable_ok,
  input wire logic            hs_pwm,
  input wire logic            overcurrent_guard,
  input wire logic            overvoltage_guard,
  // Outputs
  input wire logic            high_side_switch,
  input wire logic            low_side_switch,
  input wire logic            supply_valid,
  input wire logic [SS_W-1:0] soft_start_level,
  input wire logic [3:0]      ls_duty_eighths
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic pwr_ok;
  assign pwr_ok = bias_ok && enable_ok;
  chk_valid_rise: assert property (pwr_ok |=> supply_valid)
    else $error("supply_valid missing");
  chk_valid_fall: assert property (!pwr_ok |=> !supply_valid && soft_start_level == 0)
    else $error("supply_valid or level kept");
  chk_drivers_off: assert property (!pwr_ok |=> !high_side_switch && !low_side_switch)
    else $error("driver on while monitor low");
  chk_start_gate: assert property (!supply_valid |-> soft_start_level == 0)
    else $error("ramp before supply_valid");
  chk_level_step: assert property (supply_valid && $past(supply_valid) && !$past(rst)
    |-> soft_start_level - $past(soft_start_level) <= 1)
    else $error("level jump");
  chk_level_cap: assert property (soft_start_level <= SS_MAX_CODE)
    else $error("level above final");
  chk_duty_step: assert property (supply_valid && $changed(ls_duty_eighths)
    && ls_duty_eighths != 0 |-> ls_duty_eighths == $past(ls_duty_eighths) + 4'h1)
    else $error("duty step wrong");
  chk_guard_high: assert property (overcurrent_guard || overvoltage_guard
    |=> !high_side_switch)
    else $error("high side on in fault");
  chk_guard_low: assert property (overcurrent_guard || hs_pwm |=> !low_side_switch)
    else $error("low side on in fault");
endmodule

bind rss_sequencer rss_sequencer_chk u_chk (
  .clk               (clk),
  .rst               (rst),
  .bias_ok           (bias_ok),
  .enable_ok         (enable_ok),
  .hs_pwm            (hs_pwm),
  .overcurrent_guard (overcurrent_guard),
  .overvoltage_guard (overvoltage_guard),
  .high_side_switch  (high_side_switch),
  .low_side_switch   (low_side_switch),
  .supply_valid      (supply_valid),
  .soft_start_level  (soft_start_level),
  .ls_duty_eighths   (ls_duty_eighths)
);

/* File: tb/test_rss_sequencer.sv */
// Self-checking bench for the start-up sequencer.
// Assumes short ramp steps and an eight-cycle switching period.
`timescale 1ns/1ps
module test_rss_sequencer;
  import rss_pkg::*;
  logic clk = 0, rst = 1, bias_ok = 0, enable_ok = 0, hs_pwm = 0, ls_pwm = 0;
  logic overcurrent_guard = 0, overvoltage_guard = 0;
  logic high_side_switch, low_side_switch, supply_valid, soft_start_active, rise_window;
  logic [SS_W-1:0] soft_start_level;
  logic [3:0] ls_duty_eighths;
  int failures = 0, cmp_count = 0, cyc = 0, ls_on = 0;
  // Rows: bias, enable, expected supply_valid
  logic [2:0] rows [4] = '{3'h0, 3'h4, 3'h2, 3'h7};
  rss_sequencer #(
    .STEP_CYC   (2),
    .PERIOD_LEN (8)
  ) u_rss_sequencer (
    .clk               (clk),
    .rst               (rst),
    .bias_ok           (bias_ok),
    .enable_ok         (enable_ok),
    .hs_pwm            (hs_pwm),
    .ls_pwm            (ls_pwm),
    .overcurrent_guard (overcurrent_guard),
    .overvoltage_guard (overvoltage_guard),
    .high_side_switch  (high_side_switch),
    .low_side_switch   (low_side_switch),
    .supply_valid      (supply_valid),
    .soft_start_active (soft_start_active),
    .rise_window       (rise_window),
    .soft_start_level  (soft_start_level),
    .ls_duty_eighths   (ls_duty_eighths)
  );
  initial forever #25 clk = ~clk;
  task automatic stop_test;
    $display("failures %0d cmp_count %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse;
    @(posedge clk) hs_pwm <= 1;
    @(posedge clk) hs_pwm <= 0;
    ls_on = 0;
    repeat (6) begin
      tick(1);
      ls_on += low_side_switch;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    tick(2);
    @(posedge clk) rst <= 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) {bias_ok, enable_ok} <= rows[i][2:1];
      ls_pwm <= 1;
      tick(2);
      check(supply_valid, rows[i][0]);
      check({high_side_switch, low_side_switch}, 0);
    end
    tick(3);
    check(ls_duty_eighths, 0);
    check(low_side_switch, 0);
    pulse();
    pulse();
    for (int d = 1; d <= 8; d++) begin
      check(ls_duty_eighths, d);
      check(ls_on, (d < 6) ? d : 6);
      repeat (16) pulse();
    end
    check(rise_window, 1);
    check(soft_start_active, 1);
    for (int k = 0; k < 3000 && soft_start_level != SS_MAX_CODE; k++) tick(1);
    tick(2);
    check(soft_start_level, SS_MAX_CODE);
    check({soft_start_active, rise_window}, 0);
    check(low_side_switch, 1);
    @(posedge clk) overcurrent_guard <= 1;
    hs_pwm <= 1;
    tick(2);
    check({high_side_switch, low_side_switch}, 0);
    @(posedge clk) overcurrent_guard <= 0;
    tick(2);
    check(high_side_switch, 1);
    @(posedge clk) overvoltage_guard <= 1;
    tick(2);
    check(high_side_switch, 0);
    @(posedge clk) overvoltage_guard <= 0;
    @(posedge clk) enable_ok <= 0;
    tick(2);
    check({high_side_switch, soft_start_level, ls_duty_eighths}, 0);
    @(posedge clk) enable_ok <= 1;
    hs_pwm <= 0;
    tick(4);
    check(supply_valid, 1);
    check(ls_duty_eighths, 0);
    pulse();
    check(ls_duty_eighths, 1);
    check(ls_on, 1);
    stop_test();
  end
endmodule
